/* File: src/fault_mon_pkg.sv */
package fault_mon_pkg;
    // ------------------------------------------------------------
    // alarm indexes
    // ------------------------------------------------------------
    localparam int ALM_N        = 11;
    localparam int A_DEV_ON     = 0;
    localparam int A_CON_WARN   = 1;
    localparam int A_HOME_WARN  = 2;
    localparam int A_GEAR       = 3;
    localparam int A_SENS_RUN   = 4;
    localparam int A_SENS_INIT  = 5;
    localparam int A_ROTOR_INIT = 6;
    localparam int A_MOTOR_COMB = 7;
    localparam int A_STORE      = 8;
    localparam int A_OVERVOLT   = 9;
    localparam int A_UNDERVOLT  = 10;
    // alarms that the clear input cannot remove
    localparam logic [ALM_N-1:0] NO_RESET_MASK = 11'h7F8;
    // alarms that leave motor current on
    localparam logic [ALM_N-1:0] KEEP_RUN_MASK = 11'h004;
    // ------------------------------------------------------------
    // limits
    // ------------------------------------------------------------
    localparam int GEAR_W       = 16;
    localparam logic [GEAR_W-1:0] GEAR_MIN = 16'h0064;
    localparam logic [GEAR_W-1:0] GEAR_MAX = 16'h2710;
    localparam int SPEED_W      = 16;
    localparam logic [SPEED_W-1:0] ROTOR_SPEED_LIM = 16'h000F;
    localparam int POS_W        = 32;
    // ------------------------------------------------------------
    // warning history
    // ------------------------------------------------------------
    localparam int WARN_W       = 8;
    localparam int HIST_DEPTH   = 10;
    localparam int HIST_IDX_W   = 4;
endpackage : fault_mon_pkg

/* File: src/warn_hist_if.sv */
`timescale 1ns/1ps
interface warn_hist_if;
    logic                                   push;
    logic [fault_mon_pkg::WARN_W-1:0]       code;
    logic                                   clear;
    logic [fault_mon_pkg::HIST_IDX_W-1:0]   rd_idx;
    logic [fault_mon_pkg::WARN_W-1:0]       rd_code;
    logic [fault_mon_pkg::HIST_IDX_W-1:0]   count;
    modport owner (input push, code, clear, rd_idx,
                   output rd_code, count);
    modport user  (output push, code, clear, rd_idx,
                   input rd_code, count);
endinterface : warn_hist_if

/* File: src/warn_history.sv */
`timescale 1ns/1ps
module warn_history (
    // clock and reset
    input  wire logic   core_clk_in,
    input  wire logic   arst_n_in,
    // history port
    warn_hist_if.owner  hist
);
    localparam int D = fault_mon_pkg::HIST_DEPTH;
    localparam int W = fault_mon_pkg::WARN_W;
    localparam int IW = fault_mon_pkg::HIST_IDX_W;
    localparam logic [IW-1:0] DEPTH_C = IW'(D);
    localparam logic [IW-1:0] ONE_C = 4'h1;

    logic [W-1:0]  mem_ff [D];
    logic [W-1:0]  nxt_mem [D];
    logic [IW-1:0] cnt_ff;
    logic [IW-1:0] nxt_cnt;

    // ------------------------------------------------------------
    // shift register, entry 0 newest
    // ------------------------------------------------------------
    always_comb begin
        nxt_mem = mem_ff;
        nxt_cnt = cnt_ff;
        if (hist.clear) begin
            for (int i = 0; i < D; i++) begin
                nxt_mem[i] = '0;
            end
            nxt_cnt = '0;
        end else if (hist.push) begin
            for (int i = D - 1; i > 0; i--) begin
                nxt_mem[i] = mem_ff[i-1];
            end
            nxt_mem[0] = hist.code;
            if (cnt_ff != DEPTH_C) begin
                nxt_cnt = cnt_ff + ONE_C;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < D; i++) begin
                mem_ff[i] <= '0;
            end
            cnt_ff <= '0;
        end else begin
            mem_ff <= nxt_mem;
            cnt_ff <= nxt_cnt;
        end
    end

    assign hist.rd_code = (hist.rd_idx < cnt_ff) ? mem_ff[hist.rd_idx] : '0;
    assign hist.count   = cnt_ff;

    AST_HIST_CNT_MAX: assert property (@(posedge core_clk_in)
        disable iff (!arst_n_in) cnt_ff <= DEPTH_C)
        else $error("history count above depth");
    AST_HIST_NEWEST: assert property (@(posedge core_clk_in)
        disable iff (!arst_n_in) hist.push && !hist.clear
        |=> mem_ff[0] == $past(hist.code))
        else $error("newest entry not stored");
    AST_HIST_CLEAR: assert property (@(posedge core_clk_in)
        disable iff (!arst_n_in) hist.clear |=> cnt_ff == '0)
        else $error("history not cleared");
endmodule : warn_history

/* File: src/motor_driver_fault_monitor.sv */
`timescale 1ns/1ps
module motor_driver_fault_monitor #(
    parameter int WARN_N = 8
) (
    // clock and reset
    input  wire logic                                   core_clk_in,
    input  wire logic                                   arst_n_in,
    // host discrete inputs (pins)
    input  wire logic                                   current_enable_in,
    input  wire logic                                   home_start_in,
    input  wire logic                                   alarm_clear_input_in,
    input  wire logic                                   hist_clear_in,
    // motor state from core logic
    input  wire logic                                   init_busy_in,
    input  wire logic                                   motor_running_in,
    input  wire logic [fault_mon_pkg::POS_W-1:0]        pos_deviation_in,
    input  wire logic [fault_mon_pkg::POS_W-1:0]        deviation_alarm_limit_param_in,
    input  wire logic [fault_mon_pkg::GEAR_W-1:0]       gear_resolution_in,
    input  wire logic [fault_mon_pkg::SPEED_W-1:0]      shaft_speed_in,
    // fault sources
    input  wire logic                                   sensor_err_in,
    input  wire logic                                   motor_unsupported_in,
    input  wire logic                                   store_corrupt_in,
    input  wire logic                                   overvolt_in,
    input  wire logic                                   undervolt_in,
    // warning causes, one bit per warning code
    input  wire logic [WARN_N-1:0]                      warn_cause_in,
    input  wire logic                                   off_dev_warn_in,
    input  wire logic                                   abn_data_warn_in,
    // history read
    input  wire logic [fault_mon_pkg::HIST_IDX_W-1:0]   hist_rd_idx_in,
    output logic [fault_mon_pkg::WARN_W-1:0]            hist_rd_code_out,
    output logic [fault_mon_pkg::HIST_IDX_W-1:0]        hist_count_out,
    // status outputs
    output logic                                        alarm_output_out,
    output logic                                        warning_output_out,
    output logic                                        motor_stop_out,
    output logic [fault_mon_pkg::ALM_N-1:0]             alarm_flags_out
);
    localparam int N = fault_mon_pkg::ALM_N;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pin_s1_ff, pin_s2_ff, nxt_s1;
    always_comb begin
        nxt_s1 = {current_enable_in, home_start_in,
                  alarm_clear_input_in, hist_clear_in};
    end
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_s1_ff <= 4'h0;
            pin_s2_ff <= 4'h0;
        end else begin
            pin_s1_ff <= nxt_s1;
            pin_s2_ff <= pin_s1_ff;
        end
    end
    logic cen_s, home_s, clr_s, hclr_s;
    assign {cen_s, home_s, clr_s, hclr_s} = pin_s2_ff;

    // ------------------------------------------------------------
    // edge and power-up state
    // ------------------------------------------------------------
    logic cen_d_ff, home_d_ff, clr_d_ff, gear_done_ff;
    logic nxt_cen_d, nxt_home_d, nxt_clr_d, nxt_gear_done;
    logic clr_fall, cen_rise, home_rise, gear_chk;
    always_comb begin
        nxt_cen_d     = cen_s;
        nxt_home_d    = home_s;
        nxt_clr_d     = clr_s;
        nxt_gear_done = gear_done_ff | gear_chk;
    end
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cen_d_ff     <= 1'b0;
            home_d_ff    <= 1'b0;
            clr_d_ff     <= 1'b0;
            gear_done_ff <= 1'b0;
        end else begin
            cen_d_ff     <= nxt_cen_d;
            home_d_ff    <= nxt_home_d;
            clr_d_ff     <= nxt_clr_d;
            gear_done_ff <= nxt_gear_done;
        end
    end
    assign clr_fall  = clr_d_ff & ~clr_s;
    assign cen_rise  = cen_s & ~cen_d_ff;
    assign home_rise = home_s & ~home_d_ff;
    // gear checked once, when power-up initialisation finishes
    assign gear_chk  = ~gear_done_ff & ~init_busy_in;

    // ------------------------------------------------------------
    // alarm causes and latch
    // ------------------------------------------------------------
    logic [N-1:0] cause, alm_ff, nxt_alm;
    always_comb begin
        cause = '0;
        cause[fault_mon_pkg::A_DEV_ON] = cen_s &&
            pos_deviation_in > deviation_alarm_limit_param_in;
        cause[fault_mon_pkg::A_CON_WARN] = cen_rise && off_dev_warn_in;
        cause[fault_mon_pkg::A_HOME_WARN] =
            home_rise && abn_data_warn_in;
        cause[fault_mon_pkg::A_GEAR] = gear_chk &&
            (gear_resolution_in < fault_mon_pkg::GEAR_MIN ||
             gear_resolution_in > fault_mon_pkg::GEAR_MAX);
        cause[fault_mon_pkg::A_SENS_RUN] =
            sensor_err_in && motor_running_in && !init_busy_in;
        cause[fault_mon_pkg::A_SENS_INIT] =
            sensor_err_in && init_busy_in;
        cause[fault_mon_pkg::A_ROTOR_INIT] = init_busy_in &&
            shaft_speed_in >= fault_mon_pkg::ROTOR_SPEED_LIM;
        cause[fault_mon_pkg::A_MOTOR_COMB] = motor_unsupported_in;
        cause[fault_mon_pkg::A_STORE] = store_corrupt_in;
        cause[fault_mon_pkg::A_OVERVOLT] = overvolt_in;
        cause[fault_mon_pkg::A_UNDERVOLT] = undervolt_in;
        nxt_alm = alm_ff;
        if (clr_fall) begin
            nxt_alm = alm_ff & fault_mon_pkg::NO_RESET_MASK;
        end
        nxt_alm = nxt_alm | cause;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic nxt_alarm_out, nxt_warn_out, nxt_stop;
    always_comb begin
        nxt_alarm_out = ~|nxt_alm;
        nxt_stop = |(nxt_alm & ~fault_mon_pkg::KEEP_RUN_MASK);
        nxt_warn_out = |warn_cause_in;
    end
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            alm_ff             <= '0;
            alarm_output_out   <= 1'b0;
            motor_stop_out     <= 1'b0;
            warning_output_out <= 1'b0;
        end else begin
            alm_ff             <= nxt_alm;
            alarm_output_out   <= nxt_alarm_out;
            motor_stop_out     <= nxt_stop;
            warning_output_out <= nxt_warn_out;
        end
    end
    assign alarm_flags_out = alm_ff;

    // ------------------------------------------------------------
    // warning history: record the lowest-numbered newly arising warning each cycle
    // ------------------------------------------------------------
    logic [WARN_N-1:0] wprev_ff, nxt_wprev, wnew;
    logic [fault_mon_pkg::WARN_W-1:0] wcode;
    always_comb begin
        nxt_wprev = warn_cause_in;
        wnew = warn_cause_in & ~wprev_ff;
        wcode = '0;
        for (int i = WARN_N - 1; i >= 0; i--) begin
            if (wnew[i]) begin
                wcode = fault_mon_pkg::WARN_W'(i + 1);
            end
        end
    end
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wprev_ff <= '0;
        end else begin
            wprev_ff <= nxt_wprev;
        end
    end

    warn_hist_if hif ();
    assign hif.push   = |wnew;
    assign hif.code   = wcode;
    assign hif.clear  = hclr_s;
    assign hif.rd_idx = hist_rd_idx_in;

    warn_history u_hist (
        .core_clk_in (core_clk_in),
        .arst_n_in   (arst_n_in),
        .hist        (hif)
    );

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hist_rd_code_out <= '0;
            hist_count_out   <= '0;
        end else begin
            hist_rd_code_out <= hif.rd_code;
            hist_count_out   <= hif.count;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_DEV_ON: assert property (@(posedge core_clk_in)
        disable iff (!arst_n_in)
        cen_s && pos_deviation_in > deviation_alarm_limit_param_in
        |=> alm_ff[fault_mon_pkg::A_DEV_ON] ##1 !alarm_output_out)
        else $error("deviation alarm missing");
    AST_CON_WARN: assert property (@(posedge core_clk_in)
        disable iff (!arst_n_in) cen_rise && off_dev_warn_in
        |=> alm_ff[fault_mon_pkg::A_CON_WARN])
        else $error("enable during warning not alarmed");
    AST_HOME_WARN: assert property (@(posedge core_clk_in)
        disable iff (!arst_n_in) home_rise && abn_data_warn_in
        |=> alm_ff[fault_mon_pkg::A_HOME_WARN] ##1 !motor_stop_out)
        else $error("homing alarm wrong");
    AST_GEAR: assert property (@(posedge core_clk_in)
        disable iff (!arst_n_in) gear_chk &&
        gear_resolution_in > fault_mon_pkg::GEAR_MAX
        |=> alm_ff[fault_mon_pkg::A_GEAR])
        else $error("gear alarm missing");
    AST_SENS_INIT: assert property (@(posedge core_clk_in)
        disable iff (!arst_n_in) sensor_err_in && init_busy_in
        |=> alm_ff[fault_mon_pkg::A_SENS_INIT])
        else $error("initial sensor alarm missing");
    AST_ROTOR: assert property (@(posedge core_clk_in)
        disable iff (!arst_n_in) init_busy_in &&
        shaft_speed_in == fault_mon_pkg::ROTOR_SPEED_LIM
        |=> alm_ff[fault_mon_pkg::A_ROTOR_INIT])
        else $error("rotor alarm missing");
    AST_WARN: assert property (@(posedge core_clk_in)
        disable iff (!arst_n_in) warn_cause_in == '0
        |=> !warning_output_out)
        else $error("warning not self-cleared");
    AST_NORESET: assert property (@(posedge core_clk_in)
        disable iff (!arst_n_in) alm_ff[fault_mon_pkg::A_OVERVOLT]
        |=> alm_ff[fault_mon_pkg::A_OVERVOLT])
        else $error("non-resettable alarm cleared");
    AST_CLEAR: assert property (@(posedge core_clk_in)
        disable iff (!arst_n_in) clr_fall && cause == '0
        |=> (alm_ff & ~fault_mon_pkg::NO_RESET_MASK) == '0)
        else $error("resettable alarm not cleared");
endmodule : motor_driver_fault_monitor

/* File: tb/host_pins_model.sv */
`timescale 1ns/1ps
module host_pins_model (
    // clock
    input  wire logic core_clk_in,
    // warning state seen by the host
    input  wire logic off_dev_warn_in,
    // host pins
    output logic      current_enable_out,
    output logic      home_start_out,
    output logic      alarm_clear_out,
    output logic      hist_clear_out
);
    // ------------------------------------------------------------
    // pin registers: 0 enable, 1 home, 2 alarm clear, 3 history clear
    // ------------------------------------------------------------
    logic [3:0] pins_ff = 4'h0;

    assign current_enable_out = pins_ff[0];
    assign home_start_out     = pins_ff[1];
    assign alarm_clear_out    = pins_ff[2];
    assign hist_clear_out     = pins_ff[3];

    // on then off, high long enough to pass the synchroniser
    task automatic pulse_pin(input int sel);
        @(posedge core_clk_in);
        pins_ff[sel] <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        pins_ff[sel] <= 1'b0;
        repeat (6) @(posedge core_clk_in);
    endtask : pulse_pin

    // a careful host will not enable current during the warning
    task automatic set_enable(input logic v, input bit override);
        @(posedge core_clk_in);
        if (!(v && off_dev_warn_in && !override)) begin
            pins_ff[0] <= v;
        end
        repeat (5) @(posedge core_clk_in);
    endtask : set_enable
endmodule : host_pins_model

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
    logic        core_clk_in = 1'b0;
    logic        arst_n_in   = 1'b0;
    logic        busy, run, serr, unsup, sbad, ov, uv, offw, abnw;
    logic [31:0] dev, lim;
    logic [15:0] gear, speed;
    logic [7:0]  wcause;
    logic [3:0]  rd_idx;
    wire logic   c_en, home, clr, hclr;
    logic [7:0]  rd_code;
    logic [3:0]  cnt;
    logic        alarm_output, warning_output, stop;
    logic [10:0] flags;
    int          error_cnt = 0;
    int          n_checks  = 0;
    int          cyc       = 0;
    logic [15:0] gv [4] = '{16'h0063, 16'h0064, 16'h2710, 16'h2711};

    always #25 core_clk_in = ~core_clk_in;

    host_pins_model host_pins_model_i (
        .core_clk_in(core_clk_in), .off_dev_warn_in(offw),
        .current_enable_out(c_en), .home_start_out(home),
        .alarm_clear_out(clr), .hist_clear_out(hclr));

    motor_driver_fault_monitor #(.WARN_N(8)) motor_driver_fault_monitor_i (
        .core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
        .current_enable_in(c_en), .home_start_in(home),
        .alarm_clear_input_in(clr), .hist_clear_in(hclr),
        .init_busy_in(busy), .motor_running_in(run),
        .pos_deviation_in(dev), .deviation_alarm_limit_param_in(lim),
        .gear_resolution_in(gear), .shaft_speed_in(speed),
        .sensor_err_in(serr), .motor_unsupported_in(unsup),
        .store_corrupt_in(sbad), .overvolt_in(ov), .undervolt_in(uv),
        .warn_cause_in(wcause), .off_dev_warn_in(offw),
        .abn_data_warn_in(abnw), .hist_rd_idx_in(rd_idx),
        .hist_rd_code_out(rd_code), .hist_count_out(cnt),
        .alarm_output_out(alarm_output), .warning_output_out(warning_output),
        .motor_stop_out(stop), .alarm_flags_out(flags));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic wc(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask : wc

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic power_cycle();
        @(posedge core_clk_in);
        arst_n_in <= 1'b0;
        wc(3);
        arst_n_in <= 1'b1;
        wc(3);
    endtask : power_cycle

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    // raise one non-resettable alarm, try to clear it, then power cycle
    task automatic trip(input int idx);
        @(posedge core_clk_in);
        case (idx)
            fault_mon_pkg::A_SENS_RUN: begin
                run  <= 1'b1;
                serr <= 1'b1;
            end
            fault_mon_pkg::A_SENS_INIT: begin
                busy <= 1'b1;
                serr <= 1'b1;
            end
            fault_mon_pkg::A_ROTOR_INIT: begin
                busy  <= 1'b1;
                speed <= 16'h000F;
            end
            fault_mon_pkg::A_MOTOR_COMB: unsup <= 1'b1;
            fault_mon_pkg::A_STORE: sbad <= 1'b1;
            fault_mon_pkg::A_OVERVOLT: ov <= 1'b1;
            default: uv <= 1'b1;
        endcase
        wc(3);
        chk(flags, 32'h1 << idx);
        chk(alarm_output, 0);
        chk(stop, 1);
        @(posedge core_clk_in);
        {run, serr, busy, unsup, sbad, ov, uv} <= 7'h00;
        speed <= 16'h0000;
        host_pins_model_i.pulse_pin(2);
        chk(flags, 32'h1 << idx);
        power_cycle();
        chk(flags, 0);
    endtask : trip

    // ------------------------------------------------------------
    // timeout
    // ------------------------------------------------------------
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {run, serr, unsup, sbad, ov, uv, offw, abnw} = 8'h00;
        busy = 1'b1;
        dev = 32'h0;
        lim = 32'h0000_03E8;
        gear = 16'h03E8;
        speed = 16'h0000;
        wcause = 8'h00;
        rd_idx = 4'h0;
        wc(12);
        arst_n_in <= 1'b1;
        wc(2);
        busy <= 1'b0;
        wc(3);
        chk(alarm_output, 1);
        chk(flags, 0);
        chk(warning_output, 0);
        chk(stop, 0);
        $display("test reset done");
        dev <= 32'h0000_03E9;
        wc(3);
        chk(flags, 0);
        dev <= 32'h0000_03E8;
        host_pins_model_i.set_enable(1'b1, 1'b0);
        chk(flags, 0);
        dev <= 32'h0000_03E9;
        wc(3);
        chk(flags, 32'h1);
        chk(stop, 1);
        dev <= 32'h0;
        wc(3);
        chk(alarm_output, 0);
        host_pins_model_i.pulse_pin(2);
        chk(flags, 0);
        chk(alarm_output, 1);
        host_pins_model_i.set_enable(1'b0, 1'b0);
        $display("test deviation done");
        offw <= 1'b1;
        host_pins_model_i.set_enable(1'b1, 1'b0);
        chk(flags, 0);
        host_pins_model_i.set_enable(1'b1, 1'b1);
        chk(flags, 32'h2);
        offw <= 1'b0;
        host_pins_model_i.set_enable(1'b0, 1'b0);
        host_pins_model_i.pulse_pin(2);
        chk(flags, 0);
        host_pins_model_i.pulse_pin(1);
        chk(flags, 0);
        abnw <= 1'b1;
        host_pins_model_i.pulse_pin(1);
        chk(flags, 32'h4);
        chk(alarm_output, 0);
        chk(stop, 0);
        abnw <= 1'b0;
        host_pins_model_i.pulse_pin(2);
        chk(flags, 0);
        $display("test sequencing done");
        for (int i = 0; i < 4; i++) begin
            gear <= gv[i];
            busy <= 1'b1;
            power_cycle();
            busy <= 1'b0;
            wc(3);
            chk(flags, (i == 0 || i == 3) ? 32'h8 : 32'h0);
        end
        gear <= 16'h03E8;
        power_cycle();
        busy  <= 1'b1;
        speed <= 16'h000E;
        wc(3);
        chk(flags, 0);
        busy  <= 1'b0;
        speed <= 16'h0000;
        for (int k = 4; k < 11; k++) begin
            trip(k);
        end
        // running without sensor error, and sensor error while idle
        run <= 1'b1;
        wc(3);
        chk(flags, 0);
        run  <= 1'b0;
        serr <= 1'b1;
        wc(3);
        chk(flags, 0);
        serr <= 1'b0;
        // a one-cycle supply spike must stay latched
        ov   <= 1'b1;
        wc(1);
        ov   <= 1'b0;
        wc(3);
        chk(flags, 32'h200);
        chk(stop, 1);
        power_cycle();
        chk(flags, 0);
        // a second deviation limit
        lim <= 32'h0000_0010;
        dev <= 32'h0000_0011;
        host_pins_model_i.set_enable(1'b1, 1'b0);
        chk(flags, 32'h1);
        dev <= 32'h0;
        host_pins_model_i.set_enable(1'b0, 1'b0);
        host_pins_model_i.pulse_pin(2);
        chk(flags, 0);
        $display("test fatal alarms done");
        wcause <= 8'h04;
        wc(4);
        chk(warning_output, 1);
        chk(stop, 0);
        chk(cnt, 1);
        chk(rd_code, 3);
        wcause <= 8'h00;
        wc(3);
        chk(warning_output, 0);
        host_pins_model_i.pulse_pin(3);
        chk(cnt, 0);
        for (int p = 1; p <= 11; p++) begin
            wcause <= 8'h01 << ((p - 1) % 8);
            wc(2);
            wcause <= 8'h00;
            wc(2);
        end
        chk(cnt, 10);
        for (int j = 0; j <= 10; j++) begin
            rd_idx <= 4'(j);
            wc(3);
            chk(rd_code, (j == 10) ? 0 : ((10 - j) % 8) + 1);
        end
        power_cycle();
        chk(cnt, 0);
        $display("test warnings done");
        end_of_test();
    end
endmodule : tb
